// >>> csbd_ctrl.sv
// Chip select bank controller: decode, select timing, wait states and termination.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Every chip select bank has its own base, mask and control register.
// - Address bits 31..16 compare against base; masked bits are skipped.
// - With no mask bits set a bank covers exactly 64 kbyte.
// - Chip select 0 wins, down to select 7, DRAM 0, DRAM 1, default.
// - No match uses default memory settings and asserts no select or DRAM strobe.
// - Separate read and write enables; a disabled direction never asserts the select.
// - Four space masks per bank; only bank 1 also masks CPU space.
// - Select asserts only on address match, enabled direction, unmasked attributes.
// - Each bank and default memory has zero to fifteen wait states.
// - Port width is 8, 16 or 32 bits on the upper data lanes.
// - Internal termination is enabled per bank and for default memory.
// - Core transfers end on the cycle the sync acknowledge is sampled.
// - For external masters with internal termination, the block drives the acknowledge.
// - Each bank enables driving the acknowledge for external master hits.
// - With bursting on, wide operands to narrow ports become one burst.
// - With bursting off, every beat is its own nonburst transfer.
// - Address setup delays the select one cycle after the start strobe.
// - In a burst, a bank option keeps the select asserted between beats.
// - Address hold keeps address, attributes and write data one extra cycle.
// - Eight chip select outputs, each with 16-bit decode and 16-bit mask.
module csbd_ctrl
  import csbd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0][15:0] bank_base_address_reg,
  input wire csbd_mask_t [7:0] bank_mask_reg,
  input wire csbd_ctrl_t [7:0] bank_control_reg,
  input wire csbd_ctrl_t default_memory_control_reg,
  input wire logic [1:0][15:0] dram_bank_base_reg,
  input wire logic [1:0][15:0] dram_bank_mask_reg,
  input wire logic xfer_req,
  input wire logic [31:0] xfer_addr,
  input wire logic xfer_read,
  input wire logic xfer_super,
  input wire logic xfer_code,
  input wire logic xfer_cpu,
  input wire logic [1:0] xfer_size,
  input wire logic xfer_ext,
  input wire logic sync_transfer_ack_in,
  input wire logic async_transfer_ack,
  output logic sync_transfer_ack_out,
  output logic sync_transfer_ack_oe_n,
  output logic transfer_begin_strobe,
  output logic [7:0] cs_n,
  output logic [1:0] dram_sel,
  output logic dflt_active,
  output logic [1:0] port_width_select,
  output logic burst_active,
  output logic addr_hold_drive,
  output logic xfer_busy,
  output logic xfer_done
);

  // Whole state of the controller.
  typedef struct packed {
    csbd_state_t state;
    logic [3:0] sel;
    csbd_ctrl_t ctl;
    logic read;
    logic ext;
    logic [4:0] beats;
    logic [3:0] cnt;
    logic due;
    logic burst;
    logic ata_s1;
    logic ata_s2;
    logic strobe;
    logic [7:0] cs_n;
    logic [1:0] dram_sel;
    logic dflt_act;
    logic ta_out;
    logic ta_oe_n;
    logic hold_drv;
    logic busy;
    logic done;
  } csbd_st_t;

  csbd_st_t st_q;
  csbd_st_t st_d;
  csbd_dec_if dif ();
  logic ack_now;

  // Live request attributes feed the decoder in the cycle the request is taken.
  assign dif.req_addr = xfer_addr;
  assign dif.req_read = xfer_read;
  assign dif.req_super = xfer_super;
  assign dif.req_code = xfer_code;
  assign dif.req_cpu = xfer_cpu;

  csbd_decoder u_dec (
    .dif(dif),
    .bank_base_address_reg(bank_base_address_reg),
    .bank_mask_reg(bank_mask_reg),
    .bank_control_reg(bank_control_reg),
    .dram_bank_base_reg(dram_bank_base_reg),
    .dram_bank_mask_reg(dram_bank_mask_reg)
  );

  // Bytes carried by an operand of each request size.
  function automatic logic [4:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_bytes = 5'h01;
      SZ_WORD: size_bytes = 5'h02;
      SZ_LINE: size_bytes = 5'h10;
      default: size_bytes = 5'h04;
    endcase
  endfunction

  // Number of port beats needed for one operand.
  function automatic logic [4:0] beat_count(input logic [1:0] sz, input logic [1:0] pw);
    logic [4:0] pb;
    pb = (pw == PW_8) ? 5'h01 : ((pw == PW_16) ? 5'h02 : 5'h04);
    beat_count = (size_bytes(sz) > pb) ? (size_bytes(sz) / pb) : BEATS_ONE;
  endfunction

  // First state of a new transfer: setup only delays a chip select bank.
  function automatic csbd_state_t launch_state(input csbd_ctrl_t c, input logic [3:0] s);
    launch_state = (c.addr_setup && s < SEL_DRAM0) ? ST_SETUP : ST_ACCESS;
  endfunction

  // Beat ends on the sampled sync ack when not driven by us, the synced async ack,
  // or the internal wait count running out.
  assign ack_now = (st_q.ta_oe_n && sync_transfer_ack_in) || st_q.ata_s2 || st_q.due;

  // Next-state logic for the whole controller.
  always_comb
  begin
    csbd_st_t nx;
    logic drive;
    nx = st_q;
    drive = 1'b0;
    nx.ata_s1 = async_transfer_ack;
    nx.ata_s2 = st_q.ata_s1;
    nx.strobe = 1'b0;
    nx.done = 1'b0;
    case (st_q.state)
      ST_IDLE:
      begin
        if (xfer_req)
        begin
          nx.sel = dif.hit_idx;
          if (dif.hit_idx < SEL_DRAM0)
          begin
            nx.ctl = bank_control_reg[dif.hit_idx[2:0]];
          end
          else if (dif.hit_idx == SEL_DFLT)
          begin
            nx.ctl = default_memory_control_reg;
            nx.ctl.addr_setup = 1'b0;
            nx.ctl.addr_hold = 1'b0;
          end
          else
          begin
            nx.ctl = CTRL_DRAM;
          end
          nx.read = xfer_read;
          nx.ext = xfer_ext;
          nx.beats = beat_count(xfer_size, nx.ctl.port_width_select);
          nx.burst = nx.ctl.burst_en && (nx.beats != BEATS_ONE);
          nx.state = launch_state(nx.ctl, nx.sel);
          nx.strobe = 1'b1;
          nx.cnt = 4'h0;
        end
      end
      ST_SETUP:
      begin
        nx.state = ST_ACCESS;
        nx.cnt = 4'h0;
      end
      ST_ACCESS:
      begin
        if (ack_now)
        begin
          nx.beats = st_q.beats - BEATS_ONE;
          nx.cnt = 4'h0;
          if (st_q.beats == BEATS_ONE)
          begin
            nx.done = 1'b1;
            nx.state = st_q.ctl.addr_hold ? ST_HOLD : ST_IDLE;
          end
          else if (st_q.burst)
          begin
            nx.state = st_q.ctl.burst_cs_keep ? ST_ACCESS : ST_GAP;
          end
          else if (st_q.ctl.addr_hold)
          begin
            nx.state = ST_HOLD;
          end
          else
          begin
            nx.state = launch_state(st_q.ctl, st_q.sel);
            nx.strobe = 1'b1;
          end
        end
        else if (st_q.cnt != WAIT_MAX)
        begin
          nx.cnt = st_q.cnt + 4'h1;
        end
      end
      ST_GAP:
      begin
        nx.state = ST_ACCESS;
        nx.cnt = 4'h0;
      end
      ST_HOLD:
      begin
        if (st_q.beats != 5'h00)
        begin
          nx.state = launch_state(st_q.ctl, st_q.sel);
          nx.strobe = 1'b1;
        end
        else
        begin
          nx.state = ST_IDLE;
        end
      end
      default:
      begin
        nx.state = ST_IDLE;
      end
    endcase
    // Internal count is due on the cycle where the wait states have elapsed.
    nx.due = (nx.state == ST_ACCESS) && nx.ctl.int_term_en &&
      (nx.cnt == nx.ctl.wait_states);
    // Selects follow the registered next state so outputs come from flops.
    nx.cs_n = 8'hFF;
    if (nx.sel < SEL_DRAM0 && (nx.state == ST_ACCESS || nx.state == ST_HOLD))
    begin
      nx.cs_n[nx.sel[2:0]] = 1'b0;
    end
    nx.dram_sel = 2'h0;
    if (nx.state == ST_ACCESS || nx.state == ST_HOLD)
    begin
      nx.dram_sel[0] = nx.sel == SEL_DRAM0;
      nx.dram_sel[1] = nx.sel == SEL_DRAM1;
    end
    nx.dflt_act = (nx.sel == SEL_DFLT) && (nx.state == ST_ACCESS || nx.state == ST_HOLD);
    // The acknowledge pin is driven for the whole external master access.
    drive = nx.ext && nx.ctl.int_term_en && nx.ctl.ext_ack_en && (nx.sel < SEL_DRAM0 ||
      nx.sel == SEL_DFLT);
    nx.ta_oe_n = !(drive && nx.state != ST_IDLE);
    nx.ta_out = drive && nx.due;
    nx.hold_drv = nx.state == ST_HOLD;
    nx.busy = nx.state != ST_IDLE;
    st_d = nx;
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.cs_n <= 8'hFF;
      st_q.ta_oe_n <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops.
  assign sync_transfer_ack_out = st_q.ta_out;
  assign sync_transfer_ack_oe_n = st_q.ta_oe_n;
  assign transfer_begin_strobe = st_q.strobe;
  assign cs_n = st_q.cs_n;
  assign dram_sel = st_q.dram_sel;
  assign dflt_active = st_q.dflt_act;
  assign port_width_select = st_q.ctl.port_width_select;
  assign burst_active = st_q.burst;
  assign addr_hold_drive = st_q.hold_drv;
  assign xfer_busy = st_q.busy;
  assign xfer_done = st_q.done;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence setup_start_s;
    transfer_begin_strobe && st_q.state == ST_SETUP;
  endsequence

  sequence beat_end_s;
    st_q.state == ST_ACCESS && ack_now;
  endsequence

  // Checks on select timing, termination and acknowledge drive.
  cs_onehot_a: assert property ($onehot0(~cs_n) && !(dflt_active && dram_sel != 2'h0))
    else $error("more than one bank selected");
  dflt_quiet_a: assert property (dflt_active |-> cs_n == 8'hFF && dram_sel == 2'h0)
    else $error("select asserted during default memory transfer");
  setup_delay_a: assert property (setup_start_s |-> cs_n == 8'hFF ##1 cs_n != 8'hFF)
    else $error("select not delayed by one cycle with address setup");
  no_setup_a: assert property (transfer_begin_strobe && st_q.state == ST_ACCESS &&
    st_q.sel < SEL_DRAM0 |-> cs_n != 8'hFF)
    else $error("select missing with transfer start");
  dir_enable_a: assert property (cs_n != 8'hFF |->
    (st_q.read ? st_q.ctl.rd_en : st_q.ctl.wr_en))
    else $error("select asserted for disabled direction");
  wait_count_a: assert property (st_q.due |-> st_q.ctl.int_term_en &&
    st_q.cnt == st_q.ctl.wait_states && st_q.state == ST_ACCESS)
    else $error("internal termination at wrong wait count");
  sync_end_a: assert property (st_q.state == ST_ACCESS && sync_transfer_ack_oe_n &&
    sync_transfer_ack_in |=> st_q.state != ST_ACCESS || st_q.cnt == 4'h0)
    else $error("sync acknowledge did not end the beat");
  async_end_a: assert property (st_q.state == ST_ACCESS && st_q.ata_s2 |=>
    st_q.state != ST_ACCESS || st_q.cnt == 4'h0)
    else $error("synchronised async acknowledge did not end the beat");
  ack_wait_a: assert property (st_q.state == ST_ACCESS && !st_q.ctl.int_term_en &&
    !ack_now |=> st_q.state == ST_ACCESS)
    else $error("transfer ended without acknowledge");
  ta_drive_a: assert property (sync_transfer_ack_out |-> !sync_transfer_ack_oe_n &&
    st_q.ext && st_q.ctl.ext_ack_en)
    else $error("acknowledge driven without enable");
  hold_cycle_a: assert property (beat_end_s ##0 st_q.ctl.addr_hold &&
    (!st_q.burst || st_q.beats == BEATS_ONE) |=> addr_hold_drive ##1 !addr_hold_drive)
    else $error("address hold not exactly one cycle");

  // Beat to beat behaviour of bursts, split transfers and the driven acknowledge.
  burst_keep_a: assert property (beat_end_s ##0 st_q.burst &&
    st_q.ctl.burst_cs_keep && st_q.beats != BEATS_ONE |=> $stable(cs_n))
    else $error("select dropped between kept burst beats");
  burst_gap_a: assert property (beat_end_s ##0 st_q.burst &&
    !st_q.ctl.burst_cs_keep && st_q.beats != BEATS_ONE |=> cs_n == 8'hFF ##1 cs_n != 8'hFF)
    else $error("select not released for one cycle between burst beats");
  beat_restart_a: assert property (beat_end_s ##0 !st_q.burst &&
    !st_q.ctl.addr_hold && st_q.beats != BEATS_ONE |=> transfer_begin_strobe)
    else $error("nonburst beat started without a strobe");
  ta_whole_a: assert property (xfer_busy && st_q.ext && st_q.ctl.int_term_en &&
    st_q.ctl.ext_ack_en && st_q.sel < SEL_DRAM0 |-> !sync_transfer_ack_oe_n)
    else $error("acknowledge not driven for whole external access");

endmodule
`default_nettype wire

// >>> csbd_ctrl_bench.sv
// Self-checking testbench for the chip select bank controller.
`timescale 1ns/1ps
`default_nettype none
module csbd_ctrl_bench
  import csbd_pkg::*;
;
  logic core_clk, rst_n, req, rd, sup, code, cpu, ext;
  logic [7:0][15:0] base;
  csbd_mask_t [7:0] msk;
  csbd_ctrl_t [7:0] ctl;
  csbd_ctrl_t dctl;
  logic [1:0][15:0] dbase, dmsk;
  logic [31:0] addr;
  logic [1:0] sz, dsel, pw, mmode, ds, pws;
  logic ack_out, oe_n, strobe, dflt, burst, hold, busy, done;
  logic m_sync, m_async, ack_in, df, hl, ak, oe, bst;
  logic [7:0] cs_n, csl;
  logic [3:0] mdly;
  int errors, comparisons, cyc, n, dn, fcs, strb, gaps;
  logic [1:0] tp [4] = '{PW_8, PW_8, PW_16, PW_16};
  logic [1:0] tz [4] = '{SZ_LONG, SZ_LONG, SZ_LINE, SZ_WORD};
  int te [4] = '{1, 4, 8, 1};

  // The acknowledge wire follows whichever party drives it.
  assign ack_in = oe_n ? m_sync : ack_out;

  csbd_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .bank_base_address_reg(base),
    .bank_mask_reg(msk), .bank_control_reg(ctl), .default_memory_control_reg(dctl),
    .dram_bank_base_reg(dbase), .dram_bank_mask_reg(dmsk), .xfer_req(req),
    .xfer_addr(addr), .xfer_read(rd), .xfer_super(sup), .xfer_code(code),
    .xfer_cpu(cpu), .xfer_size(sz), .xfer_ext(ext), .sync_transfer_ack_in(ack_in),
    .async_transfer_ack(m_async), .sync_transfer_ack_out(ack_out),
    .sync_transfer_ack_oe_n(oe_n), .transfer_begin_strobe(strobe), .cs_n(cs_n),
    .dram_sel(dsel), .dflt_active(dflt), .port_width_select(pw),
    .burst_active(burst), .addr_hold_drive(hold), .xfer_busy(busy), .xfer_done(done));

  csbd_mem_model MEM (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
    .dram_sel(dsel), .dflt_active(dflt), .oe_n(oe_n), .mode(mmode), .dly(mdly),
    .ack_sync(m_sync), .ack_async(m_async));

  // Clock generator.
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Cuts a hang short.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  task summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task note(input string t);
    $display("test %s finished", t);
  endtask

  // Builds a control word; f is int_term, ext_ack, burst, setup, hold, keep.
  function automatic csbd_ctrl_t mk(input logic [1:0] p, input logic [3:0] w,
    input logic [5:0] f);
    return csbd_ctrl_t'({p, w, f, 2'b11});
  endfunction

  // One transfer: request for a cycle, then record the outputs until done.
  task automatic go(input logic [31:0] a, input logic r, input logic [1:0] s);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 50)
    begin
      @(negedge core_clk);
      k++;
    end
    addr = a;
    rd = r;
    sz = s;
    req = 1'b1;
    {n, fcs, strb, gaps} = '0;
    {csl, ds, pws, df, hl, ak, oe, bst} = '0;
    while (done !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      req = 1'b0;
      n++;
      csl |= ~cs_n;
      if (fcs != 0 && cs_n === 8'hFF)
        gaps++;
      if (fcs == 0 && cs_n !== 8'hFF)
        fcs = n;
      if (cs_n !== 8'hFF)
        pws = pw;
      strb += strobe;
      {ds, df, hl, ak, oe, bst} |= {dsel, dflt, hold, ack_out, ~oe_n, burst};
    end
    dn = n;
    @(negedge core_clk);
  endtask

  // Main sequence.
  initial
  begin
    {rst_n, req, rd, sup, code, cpu, ext, addr, sz, mmode, mdly} = '0;
    for (int i = 0; i < 8; i++)
    begin
      base[i] = 16'hF000 + 16'(i);
      msk[i] = '0;
      ctl[i] = mk(PW_32, 4'h2, 6'h20);
    end
    dctl = mk(PW_32, 4'h1, 6'h20);
    dbase = {16'hE001, 16'hE000};
    dmsk = '0;
    sup = 1'b1;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk("idle cs_n", 8'hFF, cs_n);
    chk("idle ack drive busy", 2'h2, {oe_n, busy});
    base[0] = 16'h0000;
    go(32'h0000_1234, 1'b1, SZ_LONG);
    chk("cs", 8'h01, csl);
    chk("first cs", 1, fcs);
    chk("cycles", 4, dn);
    for (int w = 0; w < 16; w += 15)
    begin
      ctl[0].wait_states = 4'(w);
      go(32'h0000_0010, 1'b0, SZ_LONG);
      chk("wait cycles", w + 2, dn);
    end
    ctl[0].wait_states = 4'h2;
    note("timing");
    base[1] = 16'h0000;
    ctl[0].rd_en = 1'b0;
    go(32'h0000_0020, 1'b1, SZ_LONG);
    chk("read cs", 8'h02, csl);
    go(32'h0000_0020, 1'b0, SZ_LONG);
    chk("write cs", 8'h01, csl);
    ctl[0].rd_en = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      msk[0] = csbd_mask_t'(21'h1 << j);
      {sup, code} = 2'(j);
      go(32'h0000_0030, 1'b1, SZ_LONG);
      chk("masked cs", 8'h02, csl);
      sup = ~sup;
      go(32'h0000_0030, 1'b1, SZ_LONG);
      chk("unmasked cs", 8'h01, csl);
    end
    {msk[0], sup, code} = {21'h0, 2'b10};
    note("priority");
    base[2] = 16'h0020;
    msk[2].base_mask_field = 16'h0001;
    go(32'h0021_0000, 1'b1, SZ_LONG);
    chk("masked addr cs", 8'h04, csl);
    go(32'h0001_0000, 1'b1, SZ_LONG);
    chk("miss cs", 8'h00, csl);
    chk("miss dram", 2'h0, ds);
    chk("default", 1'b1, df);
    chk("default cycles", 3, dn);
    {mmode, mdly} = {2'h1, 4'h3};
    go(32'hE001_8000, 1'b1, SZ_LONG);
    chk("dram sel", 2'h2, ds);
    chk("dram cycles", 5, dn);
    dmsk[1] = 16'h0001;
    go(32'hE000_0000, 1'b1, SZ_LONG);
    chk("dram priority", 2'h1, ds);
    note("decode");
    mdly = 4'h1;
    ctl[0].wait_states = 4'hF;
    go(32'h0000_0040, 1'b1, SZ_LONG);
    chk("sync ack cycles", 3, dn);
    mmode = 2'h2;
    go(32'h0000_0040, 1'b1, SZ_LONG);
    chk("async ack cycles", 5, dn);
    mmode = 2'h0;
    ctl[0].wait_states = 4'h2;
    cpu = 1'b1;
    go(32'h0000_0050, 1'b1, SZ_LONG);
    chk("cpu cs", 8'h02, csl);
    msk[1].cpu_space_mask = 1'b1;
    go(32'h0000_0050, 1'b1, SZ_LONG);
    chk("cpu masked", 8'h00, csl);
    {cpu, msk[1]} = '0;
    note("termination");
    for (int i = 0; i < 4; i++)
    begin
      ctl[0] = mk(tp[i], 4'h0, {2'b10, (i == 0 || i == 3), 3'b001});
      go(32'h0000_0060, 1'b1, tz[i]);
      chk("strobes", te[i], strb);
      chk("port width", tp[i], pws);
      chk("burst", (i == 0), bst);
      chk("cs gaps", 1, gaps);
    end
    ctl[0] = mk(PW_8, 4'h0, 6'h28);
    go(32'h0000_0060, 1'b1, SZ_LONG);
    chk("burst gaps", 4, gaps);
    ctl[0] = mk(PW_32, 4'h2, 6'h26);
    go(32'h0000_0070, 1'b0, SZ_LONG);
    chk("setup cs", 2, fcs);
    chk("hold", 1'b1, hl);
    note("burst");
    ctl[0] = mk(PW_32, 4'h2, 6'h30);
    {mmode, mdly, ext} = {2'h1, 4'h0, 1'b1};
    go(32'h0000_0080, 1'b1, SZ_LONG);
    chk("ack drive", 1'b1, oe);
    chk("ack out", 1'b1, ak);
    chk("ext cycles", 4, dn);
    // The far side keeps off the acknowledge while internal termination is on.
    {mmode, ctl[0].ext_ack_en} = 3'h0;
    go(32'h0000_0080, 1'b1, SZ_LONG);
    chk("no ack out", 1'b0, ak);
    chk("no ack drive", 1'b0, oe);
    chk("self end cycles", 4, dn);
    note("external");
    summarize();
  end
endmodule
`default_nettype wire

// >>> csbd_dec_if.sv
// Request attributes passed to the bank decoder and the winning bank returned.
`timescale 1ns/1ps
`default_nettype none
interface csbd_dec_if;
  logic [31:0] req_addr;
  logic req_read;
  logic req_super;
  logic req_code;
  logic req_cpu;
  logic [3:0] hit_idx;

  modport dec (input req_addr, input req_read, input req_super, input req_code,
    input req_cpu, output hit_idx);
  modport ctl (output req_addr, output req_read, output req_super, output req_code,
    output req_cpu, input hit_idx);
endinterface
`default_nettype wire

// >>> csbd_decoder.sv
// Priority address decoder over chip select banks, DRAM banks and default memory.
`timescale 1ns/1ps
`default_nettype none
module csbd_decoder
  import csbd_pkg::*;
(
  csbd_dec_if.dec dif,
  input wire logic [7:0][15:0] bank_base_address_reg,
  input wire csbd_mask_t [7:0] bank_mask_reg,
  input wire csbd_ctrl_t [7:0] bank_control_reg,
  input wire logic [1:0][15:0] dram_bank_base_reg,
  input wire logic [1:0][15:0] dram_bank_mask_reg
);

  // Compares address bits 31..16 with a base, skipping masked bits.
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] base,
    input logic [15:0] mask);
    addr_hit = ((a ^ base) & ~mask) == 16'h0000;
  endfunction

  // Attribute masks: one of four space masks applies to a normal transfer.
  function automatic logic attr_masked(input csbd_mask_t m, input logic sup,
    input logic code);
    attr_masked = sup ? (code ? m.supervisor_code_mask : m.supervisor_data_mask)
                      : (code ? m.user_code_mask : m.user_data_mask);
  endfunction

  // Walk from the lowest priority upward so the last matching bank, the highest priority, wins.
  always_comb
  begin
    logic ok;
    ok = 1'b0;
    dif.hit_idx = SEL_DFLT;
    if (!dif.req_cpu)
    begin
      for (int d = CSBD_NUM_DRAM - 1; d >= 0; d--)
      begin
        if (addr_hit(dif.req_addr[31:16], dram_bank_base_reg[d], dram_bank_mask_reg[d]))
        begin
          dif.hit_idx = SEL_DRAM0 + 4'(d);
        end
      end
    end
    for (int i = CSBD_NUM_CS - 1; i >= 0; i--)
    begin
      // CPU space reaches only the one bank that offers a mask for it.
      if (dif.req_cpu)
      begin
        ok = (4'(i) == SEL_CPU_BANK) && !bank_mask_reg[i].cpu_space_mask;
      end
      else
      begin
        ok = !attr_masked(bank_mask_reg[i], dif.req_super, dif.req_code);
      end
      ok = ok && (dif.req_read ? bank_control_reg[i].rd_en : bank_control_reg[i].wr_en);
      if (ok && addr_hit(dif.req_addr[31:16], bank_base_address_reg[i],
          bank_mask_reg[i].base_mask_field))
      begin
        dif.hit_idx = 4'(i);
      end
    end
  end

endmodule
`default_nettype wire

// >>> csbd_mem_model.sv
// Behavioural model of the memory or peripheral answering on the select lines.
`timescale 1ns/1ps
`default_nettype none
module csbd_mem_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] cs_n,
  input wire logic [1:0] dram_sel,
  input wire logic dflt_active,
  input wire logic oe_n,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  output logic ack_sync,
  output logic ack_async
);
  logic [3:0] cnt_q;
  logic sel;
  logic hit;

  // The device answers once it has been selected for dly cycles.
  assign sel = (cs_n != 8'hFF) || (dram_sel != 2'h0) || dflt_active;
  assign hit = sel && (cnt_q == dly);
  // The acknowledge pin is left to the block while it drives it.
  assign ack_sync = hit && (mode == 2'h1) && oe_n;
  assign ack_async = hit && (mode == 2'h2);

  // Counts selected cycles; restarts after each answer.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !sel || hit)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hF)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

// >>> csbd_pkg.sv
// Shared types and constants for the chip select bank decoder.
package csbd_pkg;

  localparam int unsigned CSBD_NUM_CS = 8;
  localparam int unsigned CSBD_NUM_DRAM = 2;

  // Bank index encoding: 0 to 7 are chip selects, then DRAM banks, then default memory.
  localparam logic [3:0] SEL_DRAM0 = 4'h8;
  localparam logic [3:0] SEL_DRAM1 = 4'h9;
  localparam logic [3:0] SEL_DFLT = 4'hA;
  localparam logic [3:0] SEL_CPU_BANK = 4'h1;

  // Port width select encoding.
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;

  // Operand size encoding of a request.
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  localparam logic [3:0] WAIT_MAX = 4'hF;
  localparam logic [4:0] BEATS_ONE = 5'h01;

  // Mask register: address mask over bits 31..16 plus attribute masks.
  typedef struct packed {
    logic [15:0] base_mask_field;
    logic cpu_space_mask;
    logic supervisor_code_mask;
    logic supervisor_data_mask;
    logic user_code_mask;
    logic user_data_mask;
  } csbd_mask_t;

  // Control register of a chip select bank or of default memory.
  typedef struct packed {
    logic [1:0] port_width_select;
    logic [3:0] wait_states;
    logic int_term_en;
    logic ext_ack_en;
    logic burst_en;
    logic addr_setup;
    logic addr_hold;
    logic burst_cs_keep;
    logic rd_en;
    logic wr_en;
  } csbd_ctrl_t;

  localparam csbd_ctrl_t CTRL_DRAM = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACCESS = 3'b010,
    ST_GAP = 3'b011,
    ST_HOLD = 3'b100
  } csbd_state_t;

endpackage
